// >>> test/eppc_core_monitor.sv
module eppc_core_monitor
(
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire sample_valid,
	input wire [15:0] analog_supply,
	input wire calib_pulse_out,
	input wire slow_pulse_a,
	input wire slow_pulse_b
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] low_q;
	wire idle = calib_pulse_out & slow_pulse_a & slow_pulse_b;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// low-supply run length, saturating
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
			low_q <= 8'h00;
		else if (analog_supply >= 16'd3900)
			low_q <= 8'h00;
		else if (low_q != 8'hff)
			low_q <= low_q + 8'h01;
	// 70 leaves margin past the 65-cycle filter and its register
	a_supply_quiet: assert property (low_q > 8'd70 |-> idle)
		else $error("pulse while supply low");
	a_idle_after_reset: assert property ($rose(hresetn) |-> idle)
		else $error("pulse active right after reset");
	a_cf_cause: assert property ($fell(calib_pulse_out) |->
		$past(sample_valid) || $past(sample_valid, 2))
		else $error("calibration pulse without sample step");
	a_slow_width: assert property ($fell(slow_pulse_a) |=> !slow_pulse_a [*8])
		else $error("slow pulse a too short");
	a_slow_b_hold: assert property ($fell(slow_pulse_b) |=>
		$stable(slow_pulse_b) [*4])
		else $error("slow pulse b too short");
	a_slow_alone: assert property (!($fell(slow_pulse_a) && $fell(slow_pulse_b)))
		else $error("both slow outputs fired at once");
	a_slow_with_cf: assert property ($fell(slow_pulse_a) ||
		$fell(slow_pulse_b) |-> !calib_pulse_out)
		else $error("slow quantum without calibration quantum");
	a_bus_zero_wait: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	c_cf: cover property ($fell(calib_pulse_out));
	c_slow_a: cover property ($fell(slow_pulse_a));
	c_slow_b: cover property ($fell(slow_pulse_b));
endmodule // eppc_core_monitor

bind eppc_core eppc_core_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
	.analog_supply(analog_supply), .calib_pulse_out(calib_pulse_out),
	.slow_pulse_a(slow_pulse_a), .slow_pulse_b(slow_pulse_b));

// >>> test/eppc_core_tb.sv
`include "eppc_defines.vh"
module eppc_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hwrite, sample_valid;
	logic [1:0] htrans, sv_q;
	logic [31:0] haddr, hwdata, rv, pg;
	logic [15:0] supply;
	wire [31:0] hrdata;
	wire hreadyout, hresp, cf, pa, pb;
	int fail_count, check_count, cyc, ca, cb, cc;
	eppc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
		.analog_supply(supply), .calib_pulse_out(cf), .slow_pulse_a(pa),
		.slow_pulse_b(pb));
	eppc_counter u_cnt (.clk(hclk), .rst_n(hresetn), .pulse_a(pa),
		.pulse_b(pb), .pulse_cf(cf), .cnt_a(ca), .cnt_b(cb), .cnt_cf(cc));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task err(input string m);
		$display("[ERR] %0t %s", $time, m);
		fail_count++;
	endtask
	function automatic bit bad(input logic ok);
		check_count++;
		return ok !== 1'b1;
	endfunction
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rv = hrdata;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		bus(0, `EPPC_ADDR_CTRL, 0);
		if (bad(rv === 32'h0)) err("ctrl reset value");
		bus(0, `EPPC_ADDR_STATUS, 0);
		if (bad(rv[0] === 1'b0)) err("run before supply");
		bus(1, 12'h020, 32'hffff_ffff);
		bus(0, 12'h020, 0);
		if (bad(rv === 32'h0)) err("unmapped read");
		supply <= 16'd5000;
		repeat (80) @(posedge hclk);
		bus(0, `EPPC_ADDR_STATUS, 0);
		if (bad(rv[0] === 1'b1)) err("no run on good supply");
	endtask
	task t_gain;
		logic [31:0] p[4];
		int gn[4] = '{1, 2, 8, 16};
		bus(1, `EPPC_ADDR_SAMPLE_I, 32'h0000_0400);
		bus(1, `EPPC_ADDR_SAMPLE_V, 32'h0000_4000);
		for (int g = 0; g < 4; g++)
		begin
			bus(1, `EPPC_ADDR_CTRL, g);
			repeat (5000) @(posedge hclk);
			bus(0, `EPPC_ADDR_POWER, 0);
			p[g] = rv;
		end
		pg = p[3];
		if (bad(p[0] > 0)) err("no real power");
		for (int g = 1; g < 4; g++)
			if (bad(longint'(p[g]) * 16 >= longint'(p[0]) * gn[g] * 15 &&
				longint'(p[g]) * 16 <= longint'(p[0]) * gn[g] * 17))
				err("gain ratio");
		if (bad(cc > 0)) err("no calibration pulses");
	endtask
	task t_hpf;
		bus(1, `EPPC_ADDR_CTRL, 32'h7);
		bus(0, `EPPC_ADDR_STATUS, 0);
		if (bad(rv[1] === 1'b1)) err("compensation off");
		repeat (20000) @(posedge hclk);
		bus(0, `EPPC_ADDR_POWER, 0);
		if (bad(rv * 8 < pg)) err("dc passed filter");
		bus(1, `EPPC_ADDR_CTRL, 32'h3);
		bus(0, `EPPC_ADDR_STATUS, 0);
		if (bad(rv[1] === 1'b0)) err("compensation stuck");
	endtask
	task wait_q(output int n);
		int s;
		s = ca + cb;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (ca + cb == s);
	endtask
	task t_rate;
		int n, e;
		logic [31:0] n0;
		// 1024 per sample: fastest quantum still outlasts the pulse width
		bus(1, `EPPC_ADDR_SAMPLE_I, 32'h0000_1000);
		bus(1, `EPPC_ADDR_CTRL, 32'h18);
		bus(0, `EPPC_ADDR_PULSES, 0);
		n0 = rv;
		repeat (6000) @(posedge hclk);
		// falling rate order: each threshold grows, first interval skipped
		for (int r = 3; r >= 0; r--)
		begin
			bus(1, `EPPC_ADDR_CTRL, r << 3);
			wait_q(n);
			wait_q(n);
			e = (4 << (21 - r)) / 1024;
			if (bad((n - e) * 32 <= e && (e - n) * 32 <= e))
				err("slow quantum interval");
		end
		bus(0, `EPPC_ADDR_PULSES, 0);
		if (bad(rv - n0 >= 8)) err("no slow quanta");
		if (bad(ca - cb >= 0 && ca - cb <= 1))
			err("slow outputs not alternating");
	endtask
	task t_supply;
		int s;
		supply <= 16'd3000;
		repeat (30) @(posedge hclk);
		supply <= 16'd3950;
		repeat (100) @(posedge hclk);
		bus(0, `EPPC_ADDR_STATUS, 0);
		if (bad(rv[0] === 1'b1)) err("false supply reset");
		supply <= 16'd3000;
		repeat (80) @(posedge hclk);
		bus(0, `EPPC_ADDR_STATUS, 0);
		if (bad(rv[0] === 1'b0)) err("no supply reset");
		s = ca + cb + cc;
		repeat (3000) @(posedge hclk);
		if (bad(ca + cb + cc == s && (cf & pa & pb) === 1'b1))
			err("pulses during supply reset");
	endtask
	// ----------------------------------------
	// clock, sample steps, watchdog, main
	// ----------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		sv_q <= sv_q + 2'h1;
		sample_valid <= (sv_q == 2'h3);
		cyc++;
		if (cyc == 95000)
		begin
			err("timeout");
			finish_test;
		end
	end
	initial
	begin
		hresetn = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		supply = 16'h0;
		sv_q = 2'h0;
		sample_valid = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_gain;
		t_hpf;
		t_rate;
		t_supply;
		finish_test;
	end
endmodule // eppc_core_tb

// >>> test/eppc_counter.sv
module eppc_counter
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pulse_a,
	input wire logic pulse_b,
	input wire logic pulse_cf,
	output int cnt_a,
	output int cnt_b,
	output int cnt_cf
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] last_q;
	// ----------------------------------------
	// pulse counter, one count per falling edge
	// ----------------------------------------
	// a retriggered pulse held low reads as one; the bench times single
	// intervals only where each quantum outlasts the pulse width
	always @(posedge clk)
	begin
		last_q <= {pulse_a, pulse_b, pulse_cf};
		if (!rst_n)
		begin
			cnt_a <= 0;
			cnt_b <= 0;
			cnt_cf <= 0;
		end
		else
		begin
			cnt_a <= cnt_a + int'(last_q[2] && !pulse_a);
			cnt_b <= cnt_b + int'(last_q[1] && !pulse_b);
			cnt_cf <= cnt_cf + int'(last_q[0] && !pulse_cf);
		end
	end
endmodule // eppc_counter

// >>> verilog/eppc_accum.v
`include "eppc_defines.vh"

// ----------------------------------------
// accumulator: pulse per threshold crossing
// ----------------------------------------
module eppc_accum
(
	input wire clk,
	input wire rst_n,
	input wire clr,
	input wire step,
	input wire [31:0] inc,
	input wire [5:0] thr_log2,
	output reg pulse_n_q
)
;
	reg [47:0] acc_q;
	reg [15:0] wid_q;
	wire [47:0] thr;
	wire [47:0] sum;

	assign thr = 48'h1 << thr_log2;
	assign sum = acc_q + {16'h0000, inc};

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_q <= 48'h0;
			wid_q <= 16'h0;
			pulse_n_q <= 1'b1;
		end
		else if (clr)
		begin
			acc_q <= 48'h0;
			wid_q <= 16'h0;
			pulse_n_q <= 1'b1;
		end
		else
		begin
			if (wid_q != 16'h0)
				wid_q <= wid_q - 16'h1;
			else
				pulse_n_q <= 1'b1;
			if (step)
			begin
				// keeping the remainder keeps long-run rate exact
				if (sum >= thr)
				begin
					acc_q <= sum - thr;
					wid_q <= `EPPC_PULSE_LEN;
					pulse_n_q <= 1'b0;
				end
				else
					acc_q <= sum;
			end
		end
	end
endmodule // eppc_accum

// >>> verilog/eppc_core.v
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`include "eppc_defines.vh"

module eppc_core
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire sample_valid,
	input wire [15:0] analog_supply,
	output wire calib_pulse_out,
	output wire slow_pulse_a,
	output wire slow_pulse_b
)
;
	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	reg [4:0] ctrl_q;
	reg [15:0] smp_i_q;
	reg [15:0] smp_v_q;
	reg wr_q;
	reg [11:0] adr_q;
	reg [31:0] pulses_q;
	wire gain_sel_lsb;
	wire gain_sel_msb;
	wire highpass_enable;
	wire rate_sel_lsb;
	wire rate_sel_msb;
	wire [4:0] ctrl_rd;
	wire [15:0] smp_i_rd;
	wire [15:0] smp_v_rd;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign gain_sel_lsb = ctrl_q[`EPPC_CTRL_GAIN_LSB];
	assign gain_sel_msb = ctrl_q[`EPPC_CTRL_GAIN_MSB];
	assign highpass_enable = ctrl_q[`EPPC_CTRL_HPF];
	assign rate_sel_lsb = ctrl_q[`EPPC_CTRL_RATE_LSB];
	assign rate_sel_msb = ctrl_q[`EPPC_CTRL_RATE_MSB];
	// a read right behind a write to the same word must see the new value
	assign ctrl_rd = (wr_q && adr_q == `EPPC_ADDR_CTRL) ?
		hwdata[4:0] : ctrl_q;
	assign smp_i_rd = (wr_q && adr_q == `EPPC_ADDR_SAMPLE_I) ?
		hwdata[15:0] : smp_i_q;
	assign smp_v_rd = (wr_q && adr_q == `EPPC_ADDR_SAMPLE_V) ?
		hwdata[15:0] : smp_v_q;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q <= 1'b0;
			adr_q <= 12'h000;
		end
		else if (hready)
		begin
			wr_q <= hsel && htrans[1] && hwrite;
			adr_q <= haddr[11:0];
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q <= `EPPC_CTRL_RESET;
			smp_i_q <= 16'h0000;
			smp_v_q <= 16'h0000;
		end
		else if (wr_q)
		begin
			if (adr_q == `EPPC_ADDR_CTRL)
				ctrl_q <= hwdata[4:0];
			else if (adr_q == `EPPC_ADDR_SAMPLE_I)
				smp_i_q <= hwdata[15:0];
			else if (adr_q == `EPPC_ADDR_SAMPLE_V)
				smp_v_q <= hwdata[15:0];
		end
	end

	// ----------------------------------------
	// supply monitor
	// ----------------------------------------
	reg run_q;
	reg [7:0] filt_q;
	wire above;
	wire below;

	// hysteresis band: must cross trip+hyst to run, trip-hyst to stop
	assign above = analog_supply >= (`EPPC_SUPPLY_TRIP_MV + `EPPC_SUPPLY_HYST_MV);
	assign below = analog_supply < (`EPPC_SUPPLY_TRIP_MV - `EPPC_SUPPLY_HYST_MV);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_q <= 1'b0;
			filt_q <= 8'h00;
		end
		else if ((run_q && below) || (!run_q && above))
		begin
			// a change must persist before it is believed
			if (filt_q == `EPPC_SUPPLY_FILT)
			begin
				run_q <= !run_q;
				filt_q <= 8'h00;
			end
			else
				filt_q <= filt_q + 8'h01;
		end
		else
			filt_q <= 8'h00;
	end

	// ----------------------------------------
	// current path: gain, high-pass, phase match
	// ----------------------------------------
	function [31:0] gain_of;
		input [1:0] sel;
		input [15:0] x;
		reg [31:0] sx;
		begin
			sx = {{16{x[15]}}, x};
			case (sel)
				2'b00: gain_of = sx;
				2'b01: gain_of = sx << 1;
				2'b10: gain_of = sx << 3;
				default: gain_of = sx << 4;
			endcase
		end
	endfunction

	reg [31:0] hp_avg_q;
	reg [31:0] cur_d1_q;
	reg [31:0] cur_q;
	wire [31:0] cur_g;
	wire [31:0] hp_out;
	wire [31:0] comp;

	assign cur_g = gain_of({gain_sel_msb, gain_sel_lsb}, smp_i_q);
	assign hp_out = cur_g - hp_avg_q;
	// phase lead of the high-pass is offset by a half-sample lag
	assign comp = $signed(hp_out) + $signed(cur_d1_q) >>> 1;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hp_avg_q <= 32'h0;
			cur_d1_q <= 32'h0;
			cur_q <= 32'h0;
		end
		else if (!run_q)
		begin
			hp_avg_q <= 32'h0;
			cur_d1_q <= 32'h0;
			cur_q <= 32'h0;
		end
		else if (sample_valid)
		begin
			// all operands signed, so the shift keeps the sign
			hp_avg_q <= $signed(hp_avg_q) +
				($signed(hp_out) >>> `EPPC_HPF_SHIFT);
			cur_d1_q <= hp_out;
			if (highpass_enable)
				cur_q <= comp;
			else
				cur_q <= cur_g;
		end
	end

	// ----------------------------------------
	// multiply and low-pass
	// ----------------------------------------
	reg [47:0] lpf_q;
	wire [47:0] prod;
	wire [31:0] pwr;

	assign prod = $signed({{16{cur_q[31]}}, cur_q}) *
		$signed({{32{smp_v_q[15]}}, smp_v_q});
	// single pole; shift sets the corner for the sample rate in use
	assign pwr = lpf_q[47] ? 32'h0 : lpf_q[47:16];

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lpf_q <= 48'h0;
		else if (!run_q)
			lpf_q <= 48'h0;
		else if (sample_valid)
			lpf_q <= $signed(lpf_q) +
				(($signed(prod) - $signed(lpf_q)) >>> `EPPC_LPF_SHIFT);
	end

	// ----------------------------------------
	// rate select and accumulators
	// ----------------------------------------
	wire [5:0] slow_log2;
	wire [5:0] cf_log2;
	wire slow_n;
	reg phase_q;

	// binary divide by 2^21..2^18 of the accumulated power
	assign slow_log2 = `EPPC_SLOW_DIV_BASE -
		{4'h0, rate_sel_msb, rate_sel_lsb};
	assign cf_log2 = slow_log2 - `EPPC_CF_RATIO_LOG2;

	eppc_accum u_slow
	(
		.clk(hclk),
		.rst_n(hresetn),
		.clr(!run_q),
		.step(sample_valid),
		.inc(pwr),
		.thr_log2(slow_log2),
		.pulse_n_q(slow_n)
	);

	eppc_accum u_cf
	(
		.clk(hclk),
		.rst_n(hresetn),
		.clr(!run_q),
		.step(sample_valid),
		.inc(pwr),
		.thr_log2(cf_log2),
		.pulse_n_q(calib_pulse_out)
	);

	reg slow_d1_q;

	// alternate the slow quantum between the two outputs (stepper drive)
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_q <= 1'b0;
			slow_d1_q <= 1'b1;
			pulses_q <= 32'h0;
		end
		else if (!run_q)
		begin
			phase_q <= 1'b0;
			slow_d1_q <= 1'b1;
		end
		else
		begin
			slow_d1_q <= slow_n;
			if (slow_d1_q && !slow_n)
				pulses_q <= pulses_q + 32'h1;
			// switch outputs only after a pulse ends, never cut one short
			if (!slow_d1_q && slow_n)
				phase_q <= !phase_q;
		end
	end

	assign slow_pulse_a = slow_n | phase_q;
	assign slow_pulse_b = slow_n | !phase_q;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (hready && hsel && htrans[1] && !hwrite)
		begin
			if (haddr[11:0] == `EPPC_ADDR_CTRL)
				hrdata <= {27'h0, ctrl_rd};
			else if (haddr[11:0] == `EPPC_ADDR_SAMPLE_I)
				hrdata <= {16'h0, smp_i_rd};
			else if (haddr[11:0] == `EPPC_ADDR_SAMPLE_V)
				hrdata <= {16'h0, smp_v_rd};
			else if (haddr[11:0] == `EPPC_ADDR_STATUS)
				hrdata <= {29'h0, phase_q, ctrl_rd[`EPPC_CTRL_HPF], run_q};
			else if (haddr[11:0] == `EPPC_ADDR_POWER)
				hrdata <= pwr;
			else if (haddr[11:0] == `EPPC_ADDR_SUPPLY)
				hrdata <= {16'h0, analog_supply};
			else if (haddr[11:0] == `EPPC_ADDR_PULSES)
				hrdata <= pulses_q;
			else
				hrdata <= 32'h0;
		end
	end
endmodule // eppc_core

// >>> verilog/eppc_defines.vh
`ifndef EPPC_DEFINES_VH
`define EPPC_DEFINES_VH

// ----------------------------------------
// bus map (byte addresses)
// ----------------------------------------
`define EPPC_ADDR_CTRL 12'h000
`define EPPC_ADDR_SAMPLE_I 12'h004
`define EPPC_ADDR_SAMPLE_V 12'h008
`define EPPC_ADDR_STATUS 12'h00c
`define EPPC_ADDR_POWER 12'h010
`define EPPC_ADDR_SUPPLY 12'h014
`define EPPC_ADDR_PULSES 12'h018

// ----------------------------------------
// control fields
// ----------------------------------------
`define EPPC_CTRL_GAIN_LSB 0
`define EPPC_CTRL_GAIN_MSB 1
`define EPPC_CTRL_HPF 2
`define EPPC_CTRL_RATE_LSB 3
`define EPPC_CTRL_RATE_MSB 4
`define EPPC_CTRL_RESET 5'h00

// ----------------------------------------
// supply monitor, codes in millivolts
// ----------------------------------------
`define EPPC_SUPPLY_TRIP_MV 16'd4000
`define EPPC_SUPPLY_HYST_MV 16'd100
`define EPPC_SUPPLY_FILT 8'd64

// ----------------------------------------
// filters and pulse shaping
// ----------------------------------------
`define EPPC_HPF_SHIFT 10
`define EPPC_LPF_SHIFT 8
`define EPPC_SLOW_DIV_BASE 6'd21
`define EPPC_CF_RATIO_LOG2 6'd11
`define EPPC_PULSE_LEN 16'd1000

`endif
